// ### eio_pkg.sv
package eio_pkg;

   // =====================================================
   // Access kinds issued by the core
   typedef enum logic [2:0]
   {
      PORT_IN_OP            = 3'h0,
      PORT_OUT_OP           = 3'h1,
      SET_SINGLE_BIT_OP     = 3'h2,
      CLEAR_SINGLE_BIT_OP   = 3'h3,
      SKIP_IF_BIT_SET_OP    = 3'h4,
      SKIP_IF_BIT_CLEAR_OP  = 3'h5,
      DATA_LOAD_OP          = 3'h6,
      DATA_STORE_OP         = 3'h7
   } eio_kind_t;

   // =====================================================
   // Address map
   localparam logic [7:0] BIT_LAST       = 8'h1f;
   localparam logic [7:0] PORT_LAST      = 8'h3f;
   localparam logic [7:0] DATA_OFS       = 8'h20;
   localparam logic [7:0] EXT_BASE       = 8'h60;
   localparam logic [7:0] SLICE_BASE     = 8'h72;
   localparam logic [7:0] SLICE_LAST     = 8'h96;
   localparam int         NUM_ENTRIES    = 37;
   localparam int         IDX_W          = 6;

   localparam logic [7:0] OFS_PC_MASK3   = 8'h73;
   localparam logic [7:0] OFS_RES_LOW    = 8'h78;
   localparam logic [7:0] OFS_RES_HIGH   = 8'h79;
   localparam logic [7:0] OFS_ADC_CS_A   = 8'h7a;
   localparam logic [7:0] OFS_ADC_CS_B   = 8'h7b;
   localparam logic [7:0] OFS_ADC_SEL    = 8'h7c;
   localparam logic [7:0] OFS_BUF_DIS0   = 8'h7e;
   localparam logic [7:0] OFS_BUF_DIS1   = 8'h7f;
   localparam logic [7:0] OFS_TMR_CA     = 8'h80;
   localparam logic [7:0] OFS_TMR_CB     = 8'h81;
   localparam logic [7:0] OFS_TMR_CC     = 8'h82;
   localparam logic [7:0] OFS_CNT_LOW    = 8'h84;
   localparam logic [7:0] OFS_CNT_HIGH   = 8'h85;
   localparam logic [7:0] OFS_CAP_LOW    = 8'h86;
   localparam logic [7:0] OFS_CAP_HIGH   = 8'h87;
   localparam logic [7:0] OFS_MA_LOW     = 8'h88;
   localparam logic [7:0] OFS_MA_HIGH    = 8'h89;
   localparam logic [7:0] OFS_MB_LOW     = 8'h8a;
   localparam logic [7:0] OFS_MB_HIGH    = 8'h8b;

   // =====================================================
   // Fields, masks and reset values
   localparam int         ADC_FLAG_BIT   = 4;
   localparam int         ADC_START_BIT  = 6;
   localparam logic [7:0] W1C_MASK_CS_A  = 8'h10;
   localparam logic [7:0] MASK_ALL       = 8'hff;
   localparam logic [7:0] MASK_NONE      = 8'h00;
   localparam logic [7:0] MASK_CS_A      = 8'hef;
   localparam logic [7:0] MASK_CS_B      = 8'h47;
   localparam logic [7:0] MASK_DIS1      = 8'h03;
   localparam logic [7:0] MASK_TMR_CA    = 8'hf3;
   localparam logic [7:0] MASK_TMR_CB    = 8'hdf;
   localparam logic [7:0] MASK_TMR_CC    = 8'hc0;
   localparam logic [7:0] RESET_VAL      = 8'h00;

endpackage

// ### eio_dec_if.sv
`timescale 1ns/100ps
interface eio_dec_if;
   import eio_pkg::*;
   eio_kind_t          kind;
   logic [7:0]         addr;
   logic [7:0]         dataAddr;
   logic [IDX_W-1:0]   idx;
   logic               legal;
   logic               hit;
   logic               isRead;
   logic               isWrite;
   logic               isRmw;
   logic               isSkip;

   modport dec (input kind, addr,
                output dataAddr, idx, legal, hit, isRead, isWrite, isRmw, isSkip);
   modport usr (output kind, addr,
                input dataAddr, idx, legal, hit, isRead, isWrite, isRmw, isSkip);
endinterface

// ### eio_access_decode.sv
`timescale 1ns/100ps
module eio_access_decode
   import eio_pkg::*;
(
   eio_dec_if.dec  bus
);

   logic        bitKind;
   logic        portKind;
   logic [7:0]  offs;

   // =====================================================
   // Form legality and data-space mapping
   always_comb
   begin
      bitKind     = bus.kind inside {SET_SINGLE_BIT_OP, CLEAR_SINGLE_BIT_OP,
                                     SKIP_IF_BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP};
      portKind    = bus.kind inside {PORT_IN_OP, PORT_OUT_OP};
      bus.legal   = 1'b1;
      if (bitKind)
      begin
         bus.legal = (bus.addr <= BIT_LAST);
      end
      else if (portKind)
      begin
         bus.legal = (bus.addr <= PORT_LAST);
      end
      bus.dataAddr = (bitKind || portKind) ? 8'(bus.addr + DATA_OFS) : bus.addr;
      // Extended region is unreachable by port forms since their mapped range ends below it
      bus.hit     = bus.legal && (bus.dataAddr >= SLICE_BASE)
                    && (bus.dataAddr <= SLICE_LAST);
      offs        = bus.dataAddr - SLICE_BASE;
      bus.idx     = offs[IDX_W-1:0];
      bus.isRead  = bus.kind inside {PORT_IN_OP, DATA_LOAD_OP};
      bus.isWrite = bus.kind inside {PORT_OUT_OP, DATA_STORE_OP,
                                     SET_SINGLE_BIT_OP, CLEAR_SINGLE_BIT_OP};
      bus.isRmw   = bus.kind inside {SET_SINGLE_BIT_OP, CLEAR_SINGLE_BIT_OP};
      bus.isSkip  = bus.kind inside {SKIP_IF_BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP};
   end

endmodule

// ### eio_register_bank.sv
`timescale 1ns/100ps
module eio_register_bank
   import eio_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         accValid,
   input  wire eio_kind_t    accKind,
   input  wire logic [7:0]   accAddr,
   input  wire logic [2:0]   accBit,
   input  wire logic [7:0]   accWdata,
   output      logic         rspValid_q,
   output      logic         rspHit_q,
   output      logic         rspErr_q,
   output      logic         rspSkip_q,
   output      logic [7:0]   rspData_q,
   input  wire logic         adcDone,
   input  wire logic [15:0]  adcResult,
   input  wire logic         cntLoad,
   input  wire logic [15:0]  cntValue,
   input  wire logic         capStrobe,
   input  wire logic [15:0]  capValue,
   output      logic [7:0]   pinChangeMask,
   output      logic [7:0]   adcCtrlA,
   output      logic [7:0]   adcCtrlB,
   output      logic [7:0]   adcInputSel,
   output      logic [7:0]   inputBufDis0,
   output      logic [7:0]   inputBufDis1,
   output      logic [7:0]   tmrCtrlA,
   output      logic [7:0]   tmrCtrlB,
   output      logic [7:0]   tmrCtrlC,
   output      logic [15:0]  tmrCount,
   output      logic [15:0]  tmrCapture,
   output      logic [15:0]  tmrMatchA,
   output      logic [15:0]  tmrMatchB
);

   // =====================================================
   // Decode
   eio_dec_if dec ();

   assign dec.kind = accKind;
   assign dec.addr = accAddr;

   eio_access_decode u_decode
   (
      .bus (dec)
   );

   // =====================================================
   // Storage, one byte per slice address
   logic [7:0]  regFile_q [NUM_ENTRIES];
   logic [7:0]  rdByte;
   logic [7:0]  rmwByte;
   logic [7:0]  wrData;
   logic        wrEn;
   logic        take;

   assign take = accValid && ce;

   function automatic logic [7:0] wrMaskOf(input logic [7:0] a);
      logic [7:0] m;
      m = MASK_NONE;
      unique case (a)
         OFS_PC_MASK3,
         OFS_ADC_SEL,
         OFS_BUF_DIS0,
         OFS_CNT_LOW,
         OFS_CNT_HIGH,
         OFS_CAP_LOW,
         OFS_CAP_HIGH,
         OFS_MA_LOW,
         OFS_MA_HIGH,
         OFS_MB_LOW,
         OFS_MB_HIGH:  m = MASK_ALL;
         OFS_ADC_CS_A: m = MASK_CS_A;
         OFS_ADC_CS_B: m = MASK_CS_B;
         OFS_BUF_DIS1: m = MASK_DIS1;
         OFS_TMR_CA:   m = MASK_TMR_CA;
         OFS_TMR_CB:   m = MASK_TMR_CB;
         OFS_TMR_CC:   m = MASK_TMR_CC;
         default:      m = MASK_NONE;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] entryNext(input logic [7:0] a,
                                            input logic [7:0] cur,
                                            input logic       we,
                                            input logic [7:0] wd);
      logic [7:0] m;
      logic [7:0] n;
      m = wrMaskOf(a);
      n = cur;
      if (we)
      begin
         n = (cur & ~m) | (wd & m);
      end
      if (we && a == OFS_ADC_CS_A)
      begin
         n = n & ~(wd & W1C_MASK_CS_A);
      end
      if (adcDone && a == OFS_RES_LOW)
      begin
         n = adcResult[7:0];
      end
      if (adcDone && a == OFS_RES_HIGH)
      begin
         n = adcResult[15:8];
      end
      if (adcDone && a == OFS_ADC_CS_A)
      begin
         // Conversion end beats a same-cycle clear of the flag
         n[ADC_FLAG_BIT]  = 1'b1;
         n[ADC_START_BIT] = 1'b0;
      end
      // A core write to the count takes priority over the timer's own update
      if (cntLoad && !we && a == OFS_CNT_LOW)
      begin
         n = cntValue[7:0];
      end
      if (cntLoad && !we && a == OFS_CNT_HIGH)
      begin
         n = cntValue[15:8];
      end
      if (capStrobe && !we && a == OFS_CAP_LOW)
      begin
         n = capValue[7:0];
      end
      if (capStrobe && !we && a == OFS_CAP_HIGH)
      begin
         n = capValue[15:8];
      end
      return n;
   endfunction

   // =====================================================
   // Read and read-modify-write data
   always_comb
   begin
      rdByte = dec.hit ? regFile_q[dec.idx] : 8'h00;
      rmwByte = rdByte;
      if (accKind == SET_SINGLE_BIT_OP)
      begin
         rmwByte[accBit] = 1'b1;
      end
      else
      begin
         rmwByte[accBit] = 1'b0;
      end
      wrData = dec.isRmw ? rmwByte : accWdata;
      wrEn   = accValid && dec.hit && dec.isWrite;
   end

   for (genvar i = 0; i < NUM_ENTRIES; i++)
   begin : g_ent
      localparam logic [7:0] ADDR = SLICE_BASE + 8'(i);
      always_ff @(posedge sys_clk)
      begin
         if (rst)
         begin
            regFile_q[i] <= RESET_VAL;
         end
         else if (ce)
         begin
            regFile_q[i] <= entryNext(ADDR, regFile_q[i],
                                      wrEn && (dec.idx == IDX_W'(i)), wrData);
         end
      end
   end

   // =====================================================
   // Response to the core
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rspValid_q <= 1'b0;
         rspHit_q   <= 1'b0;
         rspErr_q   <= 1'b0;
         rspSkip_q  <= 1'b0;
         rspData_q  <= 8'h00;
      end
      else if (ce)
      begin
         rspValid_q <= accValid;
         rspHit_q   <= accValid && dec.hit;
         rspErr_q   <= accValid && !dec.legal;
         rspSkip_q  <= accValid && dec.hit && dec.isSkip
                       && (rdByte[accBit] == (accKind == SKIP_IF_BIT_SET_OP));
         rspData_q  <= (accValid && dec.hit && dec.isRead) ? rdByte : 8'h00;
      end
   end

   // =====================================================
   // Unit-facing register views
   function automatic int ix(input logic [7:0] a);
      return int'(a - SLICE_BASE);
   endfunction

   assign pinChangeMask = regFile_q[ix(OFS_PC_MASK3)];
   assign adcCtrlA      = regFile_q[ix(OFS_ADC_CS_A)];
   assign adcCtrlB      = regFile_q[ix(OFS_ADC_CS_B)];
   assign adcInputSel   = regFile_q[ix(OFS_ADC_SEL)];
   assign inputBufDis0  = regFile_q[ix(OFS_BUF_DIS0)];
   assign inputBufDis1  = regFile_q[ix(OFS_BUF_DIS1)];
   assign tmrCtrlA      = regFile_q[ix(OFS_TMR_CA)];
   assign tmrCtrlB      = regFile_q[ix(OFS_TMR_CB)];
   assign tmrCtrlC      = regFile_q[ix(OFS_TMR_CC)];
   assign tmrCount      = {regFile_q[ix(OFS_CNT_HIGH)], regFile_q[ix(OFS_CNT_LOW)]};
   assign tmrCapture    = {regFile_q[ix(OFS_CAP_HIGH)], regFile_q[ix(OFS_CAP_LOW)]};
   assign tmrMatchA     = {regFile_q[ix(OFS_MA_HIGH)], regFile_q[ix(OFS_MA_LOW)]};
   assign tmrMatchB     = {regFile_q[ix(OFS_MB_HIGH)], regFile_q[ix(OFS_MB_LOW)]};

   // =====================================================
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_store(logic [7:0] a);
      take && accKind == DATA_STORE_OP && accAddr == a;
   endsequence

   sequence s_load(logic [7:0] a);
      take && accKind == DATA_LOAD_OP && accAddr == a;
   endsequence

   property p_bit_range;
      take && (accKind inside {SET_SINGLE_BIT_OP, CLEAR_SINGLE_BIT_OP})
      && accAddr > BIT_LAST |=> rspValid_q && rspErr_q && !rspHit_q;
   endproperty
   a_bit_range : assert property (p_bit_range)
      else $error("bit op above low range was not refused");

   property p_skip_range;
      take && (accKind inside {SKIP_IF_BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP})
      && accAddr <= BIT_LAST |=> rspValid_q && !rspErr_q && !rspSkip_q;
   endproperty
   a_skip_range : assert property (p_skip_range)
      else $error("bit test in low range answered wrongly");

   property p_flag_clear;
      s_store(OFS_ADC_CS_A) ##0 (accWdata[ADC_FLAG_BIT] && !adcDone)
      |=> !adcCtrlA[ADC_FLAG_BIT];
   endproperty
   a_flag_clear : assert property (p_flag_clear)
      else $error("written one did not clear the flag");

   property p_flag_keep;
      s_store(OFS_ADC_CS_A) ##0 (!accWdata[ADC_FLAG_BIT] && adcCtrlA[ADC_FLAG_BIT])
      |=> adcCtrlA[ADC_FLAG_BIT];
   endproperty
   a_flag_keep : assert property (p_flag_keep)
      else $error("written zero changed the flag");

   property p_flag_set_wins;
      ce && adcDone |=> adcCtrlA[ADC_FLAG_BIT] && !adcCtrlA[ADC_START_BIT];
   endproperty
   a_flag_set_wins : assert property (p_flag_set_wins)
      else $error("conversion end lost its flag");

   property p_rmw_byte;
      accValid && dec.isRmw |-> wrData == ((rdByte & ~(8'h01 << accBit))
      | ((accKind == SET_SINGLE_BIT_OP) ? (8'h01 << accBit) : 8'h00));
   endproperty
   a_rmw_byte : assert property (p_rmw_byte)
      else $error("bit op did not write back the whole byte");

   property p_port_range;
      take && (accKind inside {PORT_IN_OP, PORT_OUT_OP}) && accAddr > PORT_LAST
      |=> rspErr_q && !rspHit_q;
   endproperty
   a_port_range : assert property (p_port_range)
      else $error("port op beyond 64 addresses was not refused");

   property p_port_map;
      accValid && (accKind inside {PORT_IN_OP, PORT_OUT_OP}) && accAddr <= PORT_LAST
      |-> dec.dataAddr == accAddr + DATA_OFS && dec.dataAddr < EXT_BASE;
   endproperty
   a_port_map : assert property (p_port_map)
      else $error("port address not mapped at plus offset");

   property p_ext_only;
      accValid && (accKind inside {PORT_IN_OP, PORT_OUT_OP}) |-> !dec.hit;
   endproperty
   a_ext_only : assert property (p_ext_only)
      else $error("port form reached extended region");

   property p_count_map;
      s_store(OFS_CNT_LOW) ##1 (ce && !cntLoad) ##0 s_store(OFS_CNT_HIGH)
      |=> tmrCount == {$past(accWdata), $past(accWdata, 2)};
   endproperty
   a_count_map : assert property (p_count_map)
      else $error("count bytes not at their addresses");

   property p_capture_map;
      s_store(OFS_CAP_LOW) ##0 !capStrobe ##1 s_load(OFS_CAP_LOW)
      |=> rspHit_q && rspData_q == $past(accWdata, 2);
   endproperty
   a_capture_map : assert property (p_capture_map)
      else $error("capture low byte not at its address");

   property p_capture_high;
      s_store(OFS_CAP_HIGH) ##0 !capStrobe |=> tmrCapture[15:8] == $past(accWdata);
   endproperty
   a_capture_high : assert property (p_capture_high)
      else $error("capture high byte not at its address");

   property p_reserved_zero;
      take && accKind == DATA_LOAD_OP && accAddr >= SLICE_BASE && accAddr <= SLICE_LAST
      && wrMaskOf(accAddr) == MASK_NONE && accAddr != OFS_RES_LOW
      && accAddr != OFS_RES_HIGH |=> rspHit_q && rspData_q == 8'h00;
   endproperty
   a_reserved_zero : assert property (p_reserved_zero)
      else $error("reserved address read nonzero");

   property p_ro_result;
      s_store(OFS_RES_LOW) ##0 !adcDone |=> $stable(regFile_q[ix(OFS_RES_LOW)]);
   endproperty
   a_ro_result : assert property (p_ro_result)
      else $error("write changed the read-only result byte");

   property p_ce_freeze;
      !ce |=> $stable(rspValid_q) && $stable(rspData_q) && $stable(pinChangeMask)
      && $stable(tmrCount);
   endproperty
   a_ce_freeze : assert property (p_ce_freeze)
      else $error("state moved while clock enable was low");

endmodule

// ### eio_core_model.sv
`timescale 1ns/100ps
module eio_core_model
   import eio_pkg::*;
(
   input  wire logic        sys_clk,
   output      logic        accValid,
   output      eio_kind_t   accKind,
   output      logic [7:0]  accAddr,
   output      logic [2:0]  accBit,
   output      logic [7:0]  accWdata,
   input  wire logic        rspValid_q,
   input  wire logic        rspHit_q,
   input  wire logic        rspErr_q,
   input  wire logic        rspSkip_q,
   input  wire logic [7:0]  rspData_q
);
   logic       timedOut;
   logic       gotHit;
   logic       gotErr;
   logic       gotSkip;
   logic [7:0] gotData;

   // ==============================================
   // Idle state at time zero
   initial
   begin
      accValid = 1'b0;
      accKind  = PORT_IN_OP;
      accAddr  = 8'h00;
      accBit   = 3'h0;
      accWdata = 8'h00;
      timedOut = 1'b0;
   end

   // ==============================================
   // One access, called at a falling edge; request stays up for back-to-back use
   task automatic access(input eio_kind_t k, input logic [7:0] a, input logic [2:0] b,
                         input logic [7:0] w);
      accValid = 1'b1;
      accKind  = k;
      accAddr  = a;
      accBit   = b;
      accWdata = w;
      @(negedge sys_clk);
      if (rspValid_q !== 1'b1)
         timedOut = 1'b1;
      gotHit  = rspHit_q;
      gotErr  = rspErr_q;
      gotSkip = rspSkip_q;
      gotData = rspData_q;
   endtask

   // Released address and write-data lines show the inverse of their last value; kind and bit lines keep theirs
   task automatic idle();
      accValid = 1'b0;
      accAddr  = ~accAddr;
      accWdata = ~accWdata;
      @(negedge sys_clk);
   endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
   import eio_pkg::*;
   logic        sysClk    = 1'b0;
   logic        rst       = 1'b1;
   logic        ce        = 1'b1;
   logic        adcDone   = 1'b0;
   logic [15:0] adcResult = 16'h0000;
   logic        cntLoad   = 1'b0;
   logic [15:0] cntValue  = 16'h0000;
   logic        capStrobe = 1'b0;
   logic [15:0] capValue  = 16'h0000;
   logic        accValid;
   eio_kind_t   accKind;
   logic [7:0]  accAddr;
   logic [2:0]  accBit;
   logic [7:0]  accWdata;
   logic        rspValid_q;
   logic        rspHit_q;
   logic        rspErr_q;
   logic        rspSkip_q;
   logic [7:0]  rspData_q;
   logic [7:0]  pinChangeMask;
   logic [7:0]  adcCtrlA;
   logic [7:0]  adcCtrlB;
   logic [7:0]  adcInputSel;
   logic [7:0]  inputBufDis0;
   logic [7:0]  inputBufDis1;
   logic [7:0]  tmrCtrlA;
   logic [7:0]  tmrCtrlB;
   logic [7:0]  tmrCtrlC;
   logic [15:0] tmrMatchB;
   logic [15:0] tmrCount;
   logic [15:0] tmrCapture;
   logic [15:0] tmrMatchA;
   logic [7:0]  a;
   logic [7:0]  lim;
   int          numErrors = 0;
   int          testsRun  = 0;

   // ==============================================
   // Address and expected readback after writing all ones
   localparam logic [15:0] ROWS [28] = '{
      16'h7100, 16'h7200, 16'h73ff, 16'h7400, 16'h7700, 16'h7800, 16'h7900,
      16'h7aef, 16'h7b47, 16'h7cff, 16'h7d00, 16'h7eff, 16'h7f03, 16'h80f3,
      16'h81df, 16'h82c0, 16'h8300, 16'h84ff, 16'h85ff, 16'h86ff, 16'h87ff,
      16'h88ff, 16'h89ff, 16'h8aff, 16'h8bff, 16'h8c00, 16'h9600, 16'h9700};

   always #10 sysClk = ~sysClk;

   eio_register_bank dut (.sys_clk(sysClk), .rst(rst), .ce(ce), .accValid(accValid),
      .accKind(accKind), .accAddr(accAddr), .accBit(accBit), .accWdata(accWdata),
      .rspValid_q(rspValid_q), .rspHit_q(rspHit_q), .rspErr_q(rspErr_q),
      .rspSkip_q(rspSkip_q), .rspData_q(rspData_q), .adcDone(adcDone),
      .adcResult(adcResult), .cntLoad(cntLoad), .cntValue(cntValue),
      .capStrobe(capStrobe), .capValue(capValue), .pinChangeMask(pinChangeMask),
      .adcCtrlA(adcCtrlA), .adcCtrlB(adcCtrlB), .adcInputSel(adcInputSel),
      .inputBufDis0(inputBufDis0), .inputBufDis1(inputBufDis1), .tmrCtrlA(tmrCtrlA),
      .tmrCtrlB(tmrCtrlB), .tmrCtrlC(tmrCtrlC), .tmrCount(tmrCount),
      .tmrCapture(tmrCapture), .tmrMatchA(tmrMatchA), .tmrMatchB(tmrMatchB));

   eio_core_model core (.sys_clk(sysClk), .accValid(accValid), .accKind(accKind),
      .accAddr(accAddr), .accBit(accBit), .accWdata(accWdata),
      .rspValid_q(rspValid_q), .rspHit_q(rspHit_q), .rspErr_q(rspErr_q),
      .rspSkip_q(rspSkip_q), .rspData_q(rspData_q));

   // ==============================================
   // Compare and report
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      testsRun++;
      if (g !== e)
      begin
         numErrors++;
         $display("FAIL %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      testsRun++;
      if (g !== e)
      begin
         numErrors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      testsRun++;
      if (g !== e)
      begin
         numErrors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic op(input eio_kind_t k, input logic [7:0] ad, input logic [2:0] b,
                     input logic [7:0] w);
      core.access(k, ad, b, w);
      if (core.timedOut === 1'b1)
      begin
         numErrors++;
         $display("FAIL rspValid expected 1 seen 0");
         wrap_up();
      end
   endtask

   // Load with expected data; hit follows from the slice bounds
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      op(DATA_LOAD_OP, ad, 3'h0, 8'h00);
      chk8("loadData", e, core.gotData);
      chk1("loadHit", (ad >= SLICE_BASE) && (ad <= SLICE_LAST), core.gotHit);
      chk1("loadErr", 1'b0, core.gotErr);
   endtask

   // ==============================================
   // Main sequence
   initial
   begin
      repeat (20) @(negedge sysClk);
      rst = 1'b0;
      for (int i = 0; i < 28; i++)
      begin
         a = ROWS[i][15:8];
         rd(a, 8'h00);
         op(DATA_STORE_OP, a, 3'h0, 8'hff);
         rd(a, ROWS[i][7:0]);
      end
      chk8("pinChangeMask", 8'hff, pinChangeMask);
      chk8("adcCtrlB", 8'h47, adcCtrlB);
      chk8("adcInputSel", 8'hff, adcInputSel);
      chk8("inputBufDis0", 8'hff, inputBufDis0);
      chk8("inputBufDis1", 8'h03, inputBufDis1);
      chk8("tmrCtrlA", 8'hf3, tmrCtrlA);
      chk8("tmrCtrlB", 8'hdf, tmrCtrlB);
      chk8("tmrCtrlC", 8'hc0, tmrCtrlC);
      chk16("tmrMatchA", 16'hffff, tmrMatchA);
      chk16("tmrMatchB", 16'hffff, tmrMatchB);
      op(DATA_STORE_OP, OFS_CNT_LOW, 3'h0, 8'h34);
      op(DATA_STORE_OP, OFS_CNT_HIGH, 3'h0, 8'h12);
      chk16("tmrCount", 16'h1234, tmrCount);
      op(DATA_STORE_OP, OFS_CAP_LOW, 3'h0, 8'hcd);
      rd(OFS_CAP_LOW, 8'hcd);
      op(DATA_STORE_OP, OFS_CAP_HIGH, 3'h0, 8'hab);
      chk16("tmrCapture", 16'habcd, tmrCapture);
      core.idle();
      cntValue  = 16'hbeef;
      capValue  = 16'h5a69;
      cntLoad   = 1'b1;
      capStrobe = 1'b1;
      @(negedge sysClk);
      cntLoad   = 1'b0;
      capStrobe = 1'b0;
      rd(OFS_CNT_LOW, 8'hef);
      rd(OFS_CNT_HIGH, 8'hbe);
      rd(OFS_CAP_LOW, 8'h69);
      rd(OFS_CAP_HIGH, 8'h5a);
      core.idle();
      adcResult = 16'h0155;
      adcDone   = 1'b1;
      @(negedge sysClk);
      adcDone   = 1'b0;
      rd(OFS_ADC_CS_A, 8'hbf);
      rd(OFS_RES_LOW, 8'h55);
      rd(OFS_RES_HIGH, 8'h01);
      op(DATA_STORE_OP, OFS_ADC_CS_A, 3'h0, 8'haf);
      rd(OFS_ADC_CS_A, 8'hbf);
      op(DATA_STORE_OP, OFS_ADC_CS_A, 3'h0, 8'hbf);
      rd(OFS_ADC_CS_A, 8'haf);
      op(DATA_STORE_OP, OFS_RES_LOW, 3'h0, 8'h00);
      rd(OFS_RES_LOW, 8'h55);
      adcDone = 1'b1;
      op(DATA_STORE_OP, OFS_ADC_CS_A, 3'h0, 8'hbf);
      adcDone = 1'b0;
      rd(OFS_ADC_CS_A, 8'hbf);
      chk8("adcCtrlA", 8'hbf, adcCtrlA);
      // Port and single-bit forms at their last legal address and one past it
      for (int k = 0; k < 6; k++)
      begin
         lim = (k < 2) ? PORT_LAST : BIT_LAST;
         op(eio_kind_t'(k), lim, 3'h7, 8'h00);
         chk1("legalErr", 1'b0, core.gotErr);
         chk1("legalHit", 1'b0, core.gotHit);
         chk1("legalSkip", 1'b0, core.gotSkip);
         op(eio_kind_t'(k), lim + 8'h01, 3'h7, 8'h00);
         chk1("illegalErr", 1'b1, core.gotErr);
         chk8("illegalData", 8'h00, core.gotData);
      end
      op(PORT_OUT_OP, OFS_PC_MASK3, 3'h0, 8'h00);
      chk1("extPortErr", 1'b1, core.gotErr);
      chk8("pinChangeMask", 8'hff, pinChangeMask);
      op(DATA_LOAD_OP, EXT_BASE, 3'h0, 8'h00);
      chk1("extLoadErr", 1'b0, core.gotErr);
      op(DATA_LOAD_OP, PORT_LAST + DATA_OFS, 3'h0, 8'h00);
      chk1("dataAliasErr", 1'b0, core.gotErr);
      // A store offered while the clock enable is low must not land
      ce = 1'b0;
      core.access(DATA_STORE_OP, OFS_PC_MASK3, 3'h0, 8'h00);
      ce = 1'b1;
      chk8("frozenMask", 8'hff, pinChangeMask);
      core.idle();
      wrap_up();
   end
endmodule
